/* logic/rcw_reset_cause.sv */
// Overview of operation
// [R1] enabled clock-loss detector resets device internally, reset pin untouched
// [R2] clock-loss flag reads one only after a clock-loss reset
// [R3] reset-cause bit 2 written enables or disables the clock-loss detector
// [R4] comparator selected: reset while plus input below minus input
// [R5] comparator flag reads one only after a comparator reset
// [R6] software should enable the comparator before selecting it
// [R7] conversion pin selected: low level holds device in reset
// [R8] selected conversion pin no longer starts slow converter conversions
// [R9] conversion pin flag reads one only after a pin reset
// [R10] software should route the conversion pin before selecting it
// [R11] watchdog is a 21-bit counter on system clock between restarts
// [R12] enabled watchdog overflow resets the device, reset pin untouched
// [R13] every system reset: watchdog on, count zero, longest interval
// [R14] restart code enables the watchdog and clears its counter
// [R15] disable needs first then second code within four cycles, unlocked
// [R16] software should block interrupts around the disable pair
// [R17] lock code blocks later disables, neither enables nor restarts
// [R18] interval field selects four to the power three plus field cycles
// [R19] software keeps bit 7 zero when loading the interval
// [R20] control read returns interval field, all ones after reset
// [R21] control bit 4 reads one while the watchdog is active
// [R22] reset-cause bit 4 written forces software reset, then reads one
// [R23] power-on flag set after power-on, cleared by other resets
// [R24] pin-reset flag set after a reset from the external pin
`timescale 1ns/1ps
`default_nettype none
module rcw_reset_cause
  import rcw_pkg::*;
(
  input  wire logic       ref_clk,            // system clock, 40 MHz
  input  wire logic       nrst,               // power-on reset, synchronous, active low
  input  wire logic [7:0] sfr_addr,           // special function register address
  input  wire logic       sfr_wr,             // write strobe
  input  wire logic [7:0] sfr_wdata,          // write data
  output logic      [7:0] sfr_rdata,          // read data, one cycle after address
  input  wire logic       rst_pin_n,          // external reset pin level
  input  wire logic       cmp_zero_out,       // comparator_zero: plus above minus
  input  wire logic       conv_start_pin_two, // conversion start pin level
  input  wire logic       clock_missing,      // clock_loss_detector one-shot timed out
  output logic            clock_loss_arm,     // arms the clock_loss_detector one-shot
  output logic            slow_conv_start,    // start level to slow_converter
  output logic            sys_rst_n           // internal system reset, active low
);

  rcw_state_e             state_q, state_d;
  logic [3:0]             hold_q, hold_d;
  logic [7:0]             cause_q, cause_d;
  logic                   en_clk_q, en_clk_d;
  logic                   en_cmp_q, en_cmp_d;
  logic                   en_conv_q, en_conv_d;
  logic [DOG_CNT_W-1:0]   dog_cnt_q, dog_cnt_d;
  logic                   dog_on_q, dog_on_d;
  logic                   dog_lock_q, dog_lock_d;
  logic [2:0]             dog_int_q, dog_int_d;
  logic [2:0]             dis_win_q, dis_win_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   conv_go_q, conv_go_d;
  logic                   pin_s, cmp_s, conv_s, gone_s;
  logic                   wr_dog, wr_cause;
  logic                   pin_hit, clk_hit, cmp_hit, conv_hit, dog_hit, soft_hit;
  logic                   level_busy, any_hit;
  logic [DOG_CNT_W-1:0]   dog_last;

  // every pin and the one-shot come from outside the clock domain
  rcw_sync3 #(.RST_VAL(1'b1)) u_sync_pin (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (rst_pin_n),
    .dout    (pin_s)
  );
  rcw_sync3 #(.RST_VAL(1'b1)) u_sync_cmp (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (cmp_zero_out),
    .dout    (cmp_s)
  );
  rcw_sync3 #(.RST_VAL(1'b1)) u_sync_conv (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (conv_start_pin_two),
    .dout    (conv_s)
  );
  rcw_sync3 #(.RST_VAL(1'b0)) u_sync_gone (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (clock_missing),
    .dout    (gone_s)
  );

  // register writes only count while the core is out of reset
  assign wr_dog   = sfr_wr && (sfr_addr == DOG_CTRL_ADDR) && (state_q == ST_RUN);
  assign wr_cause = sfr_wr && (sfr_addr == CAUSE_ADDR) && (state_q == ST_RUN);

  // timeout is 4^(3+n) = 2^(6+2n) cycles; last count before overflow
  assign dog_last = (DOG_CNT_W'(1) << (DOG_EXP_BASE + {1'b0, dog_int_q, 1'b0}))
                    - DOG_CNT_W'(1);                              // see [R18]

  // reset sources; level ones keep the reset held while active
  assign pin_hit    = !pin_s;                                     // see [R24]
  assign clk_hit    = en_clk_q && gone_s;                         // see [R1]
  assign cmp_hit    = en_cmp_q && !cmp_s;                         // see [R4]
  assign conv_hit   = en_conv_q && !conv_s;                       // see [R7]
  assign dog_hit    = dog_on_q && (dog_cnt_q == dog_last);        // see [R12]
  assign soft_hit   = wr_cause && sfr_wdata[BIT_SOFT];            // see [R22]
  assign level_busy = pin_hit || clk_hit || cmp_hit || conv_hit;
  assign any_hit    = level_busy || dog_hit || soft_hit;

  // sequencer, cause capture and enables
  always_comb begin
    state_d   = state_q;
    hold_d    = hold_q;
    cause_d   = cause_q;
    en_clk_d  = en_clk_q;
    en_cmp_d  = en_cmp_q;
    en_conv_d = en_conv_q;
    case (state_q)
      ST_RUN: begin
        if (wr_cause) begin
          en_clk_d  = sfr_wdata[BIT_CLK];                         // see [R3]
          en_cmp_d  = sfr_wdata[BIT_CMP];                         // see [R4]
          en_conv_d = sfr_wdata[BIT_CONV];                        // see [R7]
        end
        if (any_hit) begin
          state_d = ST_HOLD;
          hold_d  = 4'h0;
          cause_d = 8'h00;
          // one cause only, the pin first since it also clears selections
          if (pin_hit) begin
            cause_d[BIT_PIN] = 1'b1;                              // see [R24]
            en_clk_d         = 1'b0;
            en_cmp_d         = 1'b0;
            en_conv_d        = 1'b0;
          end else if (clk_hit) begin
            cause_d[BIT_CLK] = 1'b1;                              // see [R2]
          end else if (cmp_hit) begin
            cause_d[BIT_CMP] = 1'b1;                              // see [R5]
          end else if (conv_hit) begin
            cause_d[BIT_CONV] = 1'b1;                             // see [R9]
          end else if (dog_hit) begin
            cause_d[BIT_DOG] = 1'b1;                              // see [R12]
          end else begin
            cause_d[BIT_SOFT] = 1'b1;                             // see [R22]
          end                                                     // see [R23]
        end
      end
      ST_HOLD: begin
        // level sources stretch the reset; exit counts only once all are idle
        if (level_busy) begin
          hold_d = 4'h0;                                          // see [R7]
        end else if (hold_q == RST_EXIT_CYC - 4'h1) begin
          state_d = ST_RUN;
        end else begin
          hold_d = hold_q + 4'h1;
        end
      end
      default: begin
        state_d = ST_HOLD;
        hold_d  = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q   <= ST_RUN;
      hold_q    <= 4'h0;
      cause_q   <= CAUSE_RST;
      en_clk_q  <= 1'b0;
      en_cmp_q  <= 1'b0;
      en_conv_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      hold_q    <= hold_d;
      cause_q   <= cause_d;
      en_clk_q  <= en_clk_d;
      en_cmp_q  <= en_cmp_d;
      en_conv_q <= en_conv_d;
    end
  end

  // watchdog: counter, enable, lock, interval and disable window
  always_comb begin
    dog_cnt_d  = dog_cnt_q;
    dog_on_d   = dog_on_q;
    dog_lock_d = dog_lock_q;
    dog_int_d  = dog_int_q;
    dis_win_d  = (dis_win_q != 3'h0) ? dis_win_q - 3'h1 : 3'h0;
    if (state_q == ST_HOLD || any_hit) begin
      // any system reset restores the default watchdog
      dog_cnt_d  = '0;                                            // see [R13]
      dog_on_d   = 1'b1;
      dog_lock_d = 1'b0;
      dog_int_d  = DOG_INT_RST;                                   // see [R20]
      dis_win_d  = 3'h0;
    end else begin
      if (dog_on_q) begin
        dog_cnt_d = dog_cnt_q + DOG_CNT_W'(1);                    // see [R11]
      end
      if (wr_dog) begin
        case (sfr_wdata)
          DOG_RESTART: begin
            dog_on_d  = 1'b1;                                     // see [R14]
            dog_cnt_d = '0;
          end
          DOG_DIS_FIRST: begin
            dis_win_d = DOG_DIS_WIN;                              // see [R15]
          end
          DOG_DIS_SECOND: begin
            // a late or locked second code is silently ignored
            if (dis_win_q != 3'h0 && !dog_lock_q) begin
              dog_on_d = 1'b0;                                    // see [R15]
            end
          end
          DOG_LOCK: begin
            dog_lock_d = 1'b1;                                    // see [R17]
          end
          default: begin
            if (!sfr_wdata[DOG_LOAD_BIT]) begin
              dog_int_d = sfr_wdata[2:0];                         // see [R18]
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dog_cnt_q  <= '0;
      dog_on_q   <= 1'b1;
      dog_lock_q <= 1'b0;
      dog_int_q  <= DOG_INT_RST;
      dis_win_q  <= 3'h0;
    end else begin
      dog_cnt_q  <= dog_cnt_d;
      dog_on_q   <= dog_on_d;
      dog_lock_q <= dog_lock_d;
      dog_int_q  <= dog_int_d;
      dis_win_q  <= dis_win_d;
    end
  end

  // read mux and converter start gating, both registered
  always_comb begin
    rdata_d = 8'h00;
    case (sfr_addr)
      DOG_CTRL_ADDR: begin
        rdata_d[2:0]           = dog_int_q;                       // see [R20]
        rdata_d[DOG_ACTIVE_BIT] = dog_on_q;                       // see [R21]
      end
      CAUSE_ADDR: begin
        rdata_d = {1'b0, cause_q[6:0]};                           // see [R2]
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
    // selecting the pin as a reset source takes it away from the converter
    conv_go_d = !en_conv_q && !conv_s;                            // see [R8]
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q   <= 8'h00;
      conv_go_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      conv_go_q <= conv_go_d;
    end
  end

  assign sfr_rdata       = rdata_q;
  assign slow_conv_start = conv_go_q;
  assign clock_loss_arm  = en_clk_q;
  // the clock-loss term is raw: with the clock gone no flop can carry it
  assign sys_rst_n = (state_q == ST_RUN) && !(en_clk_q && clock_missing); // see [R1]

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  clk_loss_rst_a: assert property ( // see [R1] [R2]
    (state_q == ST_RUN && clk_hit && !pin_hit) |=> (state_q == ST_HOLD && cause_q == 8'h04))
    else $error("clock loss did not reset with its flag");
  cmp_rst_a: assert property ( // see [R4] [R5]
    (state_q == ST_RUN && cmp_hit && !pin_hit && !clk_hit)
      |=> (state_q == ST_HOLD && cause_q == 8'h20))
    else $error("comparator reset or flag missing");
  conv_block_a: assert property ( // see [R8]
    en_conv_q |=> !slow_conv_start)
    else $error("selected pin still starts conversions");
  conv_hold_a: assert property ( // see [R7]
    (state_q == ST_HOLD && conv_hit) |=> state_q == ST_HOLD [*3])
    else $error("reset released while conversion pin low");
  dog_overflow_a: assert property ( // see [R12]
    (state_q == ST_RUN && dog_hit) |=> (state_q == ST_HOLD && !sys_rst_n))
    else $error("watchdog overflow did not reset");
  dog_defaults_a: assert property ( // see [R13] [R20]
    (state_q == ST_HOLD) |=> (dog_on_q && dog_cnt_q == '0 && dog_int_q == 3'h7 && !dog_lock_q))
    else $error("watchdog defaults not restored by reset");
  dog_restart_a: assert property ( // see [R14]
    (wr_dog && sfr_wdata == 8'ha5) |=> (dog_on_q && dog_cnt_q == '0))
    else $error("restart code did not clear watchdog");
  dog_disable_a: assert property ( // see [R15]
    (wr_dog && sfr_wdata == 8'hde && !dog_lock_q && !any_hit)
      ##[1:4] (wr_dog && sfr_wdata == 8'had && !dog_lock_q && !any_hit) |=> !dog_on_q)
    else $error("timely disable pair was ignored");
  dis_late_a: assert property ( // see [R15] [R17]
    (wr_dog && sfr_wdata == 8'had && dog_on_q && !any_hit && (dis_win_q == 3'h0 || dog_lock_q))
      |=> dog_on_q)
    else $error("late or locked disable took effect");
  lock_neutral_a: assert property ( // see [R17]
    (wr_dog && sfr_wdata == 8'hff && !any_hit)
      |=> (dog_lock_q && dog_on_q == $past(dog_on_q) && (!dog_on_q || dog_cnt_q != '0)))
    else $error("lock code enabled or restarted watchdog");
  soft_rst_a: assert property ( // see [R22]
    (soft_hit && !level_busy && !dog_hit) |=> (state_q == ST_HOLD && cause_q == 8'h10))
    else $error("software reset or flag missing");
  dog_status_a: assert property ( // see [R21]
    (sfr_addr == DOG_CTRL_ADDR) |=> sfr_rdata == {3'b000, $past(dog_on_q), 1'b0, $past(dog_int_q)})
    else $error("watchdog control readback wrong");

endmodule
`default_nettype wire

/* logic/rcw_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change is taken once stages two and three agree
module rcw_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic ref_clk,  // system clock
  input  wire logic nrst,     // synchronous reset, active low
  input  wire logic din,      // asynchronous level
  output logic      dout      // filtered synchronous level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  logic out_d;

  // first stage feeds only the second stage
  always_comb begin
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

/* shared/rcw_pkg.sv */
// shared constants for the reset cause collector and watchdog
`default_nettype none
package rcw_pkg;

  // special function register addresses
  localparam logic [7:0] DOG_CTRL_ADDR  = 8'hff;
  localparam logic [7:0] CAUSE_ADDR     = 8'hd7;

  // watchdog control codes
  localparam logic [7:0] DOG_RESTART    = 8'ha5;
  localparam logic [7:0] DOG_DIS_FIRST  = 8'hde;
  localparam logic [7:0] DOG_DIS_SECOND = 8'had;
  localparam logic [7:0] DOG_LOCK       = 8'hff;

  // watchdog control fields
  localparam int         DOG_LOAD_BIT   = 7;
  localparam int         DOG_ACTIVE_BIT = 4;
  localparam int         DOG_CNT_W      = 21;
  localparam logic [2:0] DOG_INT_RST    = 3'h7;
  localparam logic [2:0] DOG_DIS_WIN    = 3'h4;
  localparam logic [4:0] DOG_EXP_BASE   = 5'h06;

  // reset cause register bit positions
  localparam int         BIT_PIN        = 0;
  localparam int         BIT_POR        = 1;
  localparam int         BIT_CLK        = 2;
  localparam int         BIT_DOG        = 3;
  localparam int         BIT_SOFT       = 4;
  localparam int         BIT_CMP        = 5;
  localparam int         BIT_CONV       = 6;
  localparam logic [7:0] CAUSE_RST      = 8'h02;

  // cycles the system reset stays asserted after the last source lets go
  localparam logic [3:0] RST_EXIT_CYC   = 4'hc;

  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_HOLD = 1'b1
  } rcw_state_e;

endpackage
`default_nettype wire

/* verification/rcw_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: comparator output, reset-capable pins and the clock-loss one-shot
module rcw_far_model (
  input  wire logic ref_clk,            // system clock
  input  wire logic pin_low,            // command: pull reset pin low
  input  wire logic cmp_low,            // command: plus input below minus
  input  wire logic conv_low,           // command: conversion pin low
  input  wire logic clk_gone,           // command: clock treated as lost
  output logic      rst_pin_n,          // external reset pin, pulled up
  output logic      cmp_zero_out,       // comparator output
  output logic      conv_start_pin_two, // conversion start pin, pulled up
  output logic      clock_missing       // one-shot timed out
);
  // quiet levels before the first edge
  initial begin
    rst_pin_n          = 1'b1;
    cmp_zero_out       = 1'b1;
    conv_start_pin_two = 1'b1;
    clock_missing      = 1'b0;
  end
  // pins move just after an edge, unrelated to the block's sampling
  always @(posedge ref_clk) begin
    rst_pin_n          <= ~pin_low;                 // released pin goes to its pull-up
    cmp_zero_out       <= ~cmp_low;
    conv_start_pin_two <= ~conv_low;
    // the one-shot reports a lost clock even unarmed, so the block's own gating is exercised
    clock_missing      <= clk_gone;
  end
endmodule
`default_nettype wire

/* verification/tb_rcw_reset_cause.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rcw_reset_cause;
  import rcw_pkg::*;
  localparam int LIMIT = 20000;
  logic       ref_clk, nrst, sfr_wr, pin_low, cmp_low, conv_low, clk_gone;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_v;
  logic       rst_pin_n, cmp_zero_out, conv_start_pin_two, clock_missing;
  logic       clock_loss_arm, slow_conv_start, sys_rst_n;
  int         n_fail, compares, cyc;

  rcw_reset_cause dut_u (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rst_pin_n(rst_pin_n),
    .cmp_zero_out(cmp_zero_out), .conv_start_pin_two(conv_start_pin_two),
    .clock_missing(clock_missing), .clock_loss_arm(clock_loss_arm),
    .slow_conv_start(slow_conv_start), .sys_rst_n(sys_rst_n));
  rcw_far_model far_u (.ref_clk(ref_clk), .pin_low(pin_low),
    .cmp_low(cmp_low), .conv_low(conv_low), .clk_gone(clk_gone), .rst_pin_n(rst_pin_n),
    .cmp_zero_out(cmp_zero_out), .conv_start_pin_two(conv_start_pin_two),
    .clock_missing(clock_missing));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("mismatches=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang must still reach the report
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    v = sfr_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  // two control writes, the second gap edges after the first, nothing in between
  // with gap 1 the strobe stays high and only the data changes between the two edges
  task automatic wr_pair(input logic [7:0] d1, input logic [7:0] d2, input int gap);
    @(negedge ref_clk);
    sfr_addr  = DOG_CTRL_ADDR;
    sfr_wdata = d1;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    if (gap > 1) begin
      sfr_wr = 1'b0;
      repeat (gap - 1) @(negedge ref_clk);
    end
    sfr_wdata = d2;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic wait_lvl(input logic lvl);
    int i;
    i = 0;
    while (sys_rst_n !== lvl && i < 400) begin
      @(negedge ref_clk);
      i++;
    end
    chk({7'h00, sys_rst_n}, {7'h00, lvl});
  endtask

  // wait for the system reset, let every level source go, then read the cause
  task automatic hit(input logic [7:0] exp);
    wait_lvl(1'b0);
    // the raw clock-loss term drops reset before the cause is captured
    repeat (8) @(negedge ref_clk);
    pin_low  = 1'b0;
    cmp_low  = 1'b0;
    conv_low = 1'b0;
    clk_gone = 1'b0;
    wait_lvl(1'b1);
    rd(CAUSE_ADDR, rd_v);
    chk(rd_v, exp);
  endtask

  task automatic t_reset_vals();
    rd(CAUSE_ADDR, rd_v);
    chk(rd_v, 8'h02);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
    rd(8'h10, rd_v);
    chk(rd_v, 8'h00);
  endtask

  task automatic t_dog_disable();
    wr_pair(DOG_DIS_FIRST, DOG_DIS_SECOND, 5);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
    wr_pair(DOG_DIS_FIRST, DOG_DIS_SECOND, 1);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h07);
    wr(DOG_CTRL_ADDR, 8'h00);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h00);
    wr(DOG_CTRL_ADDR, 8'h85);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h00);
    repeat (150) @(negedge ref_clk);
    chk({7'h00, sys_rst_n}, 8'h01);
    wr(DOG_CTRL_ADDR, 8'h07);
    wr(DOG_CTRL_ADDR, DOG_RESTART);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
    wr(DOG_CTRL_ADDR, DOG_LOCK);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
    wr_pair(DOG_DIS_FIRST, DOG_DIS_SECOND, 1);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
    wr(CAUSE_ADDR, 8'h10);
    hit(8'h10);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
    wr_pair(DOG_DIS_FIRST, DOG_DIS_SECOND, 4);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h07);
    // a lock written while disabled must not switch the watchdog back on
    wr(DOG_CTRL_ADDR, DOG_LOCK);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h07);
    wr(DOG_CTRL_ADDR, DOG_RESTART);
  endtask

  // interval 0 gives 64 cycles from the restart edge to overflow
  task automatic t_dog_timeout();
    wr(DOG_CTRL_ADDR, 8'h00);
    wr(DOG_CTRL_ADDR, DOG_RESTART);
    repeat (63) @(negedge ref_clk);
    chk({7'h00, sys_rst_n}, 8'h01);
    @(negedge ref_clk);
    chk({7'h00, sys_rst_n}, 8'h00);
    hit(8'h08);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
  endtask

  // comparator already settled high before it is selected
  task automatic t_cmp();
    wr(CAUSE_ADDR, 8'h20);
    repeat (6) @(negedge ref_clk);
    chk({7'h00, sys_rst_n}, 8'h01);
    cmp_low = 1'b1;
    hit(8'h20);
    wr(CAUSE_ADDR, 8'h00);
  endtask

  task automatic t_conv();
    conv_low = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk({7'h00, slow_conv_start}, 8'h01);
    conv_low = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({7'h00, slow_conv_start}, 8'h00);
    wr(CAUSE_ADDR, 8'h40);
    conv_low = 1'b1;
    wait_lvl(1'b0);
    repeat (2) @(negedge ref_clk);
    chk({7'h00, slow_conv_start}, 8'h00);
    hit(8'h40);
    wr(CAUSE_ADDR, 8'h00);
  endtask

  task automatic t_clk_loss();
    wr(CAUSE_ADDR, 8'h04);
    @(negedge ref_clk);
    chk({7'h00, clock_loss_arm}, 8'h01);
    clk_gone = 1'b1;
    hit(8'h04);
    wr(CAUSE_ADDR, 8'h00);
    @(negedge ref_clk);
    chk({7'h00, clock_loss_arm}, 8'h00);
    clk_gone = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk({7'h00, sys_rst_n}, 8'h01);
    clk_gone = 1'b0;
  endtask

  task automatic t_pin();
    pin_low = 1'b1;
    repeat (3) @(negedge ref_clk);
    hit(8'h01);
  endtask

  // a second power-on reset in mid-run brings back the power-on flag alone
  task automatic t_por();
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    chk({7'h00, sys_rst_n}, 8'h01);
    chk({7'h00, clock_loss_arm}, 8'h00);
    rd(CAUSE_ADDR, rd_v);
    chk(rd_v, 8'h02);
    rd(DOG_CTRL_ADDR, rd_v);
    chk(rd_v, 8'h17);
  endtask

  // main sequence; reset is synchronous, so two edges load every flop
  initial begin
    n_fail    = 0;
    compares  = 0;
    cyc       = 0;
    nrst      = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr    = 1'b0;
    pin_low   = 1'b0;
    cmp_low   = 1'b0;
    conv_low  = 1'b0;
    clk_gone  = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset_vals();
    t_dog_disable();
    t_dog_timeout();
    t_cmp();
    t_conv();
    t_clk_loss();
    t_pin();
    t_por();
    print_verdict();
  end
endmodule
`default_nettype wire
